// ===== pkg/gfx_status_class_pkg.sv
package gfx_status_class_pkg;

  // Configuration space geometry.
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 32;
  localparam int CFG_BE_W = 4;
  localparam int DWORD_IDX_W = 6;

  // Printed byte offsets of the registers.
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] FUNCTION_STATUS_OFFSET = 8'h06;
  localparam logic [7:0] REVISION_NUMBER_OFFSET = 8'h08;
  localparam logic [7:0] FUNCTION_CLASS_OFFSET = 8'h09;

  // Dword indices that hold them.
  localparam logic [5:0] CMD_STATUS_DWORD = 6'h01;
  localparam logic [5:0] REV_CLASS_DWORD = 6'h02;

  // Lane positions inside each dword.
  localparam int STATUS_LSB = 16;
  localparam int REVISION_LSB = 0;
  localparam int CLASS_LSB = 8;

  // Command register fields.
  localparam int INT_DISABLE_BIT = 10;
  localparam int INT_DISABLE_LANE = 1;
  localparam logic INT_DISABLE_RESET = 1'b0;

  // Status register fields.
  localparam int PARITY_ERROR_SEEN_BIT = 15;
  localparam int SYSTEM_ERROR_SIGNALED_BIT = 14;
  localparam int MASTER_ABORT_RECEIVED_BIT = 13;
  localparam int TARGET_ABORT_RECEIVED_BIT = 12;
  localparam int TARGET_ABORT_SIGNALED_BIT = 11;
  localparam int SELECT_TIMING_MSB = 10;
  localparam int SELECT_TIMING_LSB = 9;
  localparam int MASTER_DATA_PARITY_ERROR_BIT = 8;
  localparam int BACK_TO_BACK_CAPABLE_BIT = 7;
  localparam int USER_FORMAT_FLAG_BIT = 6;
  localparam int DOUBLE_SPEED_CAPABLE_BIT = 5;
  localparam int CAPABILITY_LIST_PRESENT_BIT = 4;
  localparam int INTERRUPT_STATUS_BIT = 3;
  localparam logic [15:0] FUNCTION_STATUS_RESET = 16'h0090;
  localparam logic [1:0] SELECT_TIMING_VALUE = 2'h0;

  // Class code fields.
  localparam logic [7:0] BASE_CLASS_DISPLAY = 8'h03;
  localparam logic [7:0] SUB_CLASS_VGA = 8'h00;
  localparam logic [7:0] SUB_CLASS_NON_VGA = 8'h80;
  localparam logic [7:0] PROGRAMMING_INTERFACE_DISPLAY = 8'h00;
  localparam logic [23:0] FUNCTION_CLASS_RESET = 24'h030000;

  // Host bridge graphics control bit that selects non-VGA operation.
  localparam int HOST_GFX_NON_VGA_BIT = 1;
  localparam int HOST_GFX_CTRL_W = 16;

  // Value is arbitrary; the real stepping is set at integration.
  localparam logic [7:0] REVISION_DEFAULT = 8'h01;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b00,
    MSG_ASSERTED = 2'b01
  } intx_msg_state_e;

endpackage

// ===== src/intx_message_gen.sv
`timescale 1ns/1ns
module intx_message_gen
  import gfx_status_class_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic intxLevel,
  output logic assertMsg,
  output logic deassertMsg
);

  typedef struct packed {
    intx_msg_state_e state;
    logic assertMsg;
    logic deassertMsg;
  } msg_s;

  msg_s msg_r;
  msg_s msg_nxt;

  // One message per edge of the gated level, so a masked interrupt never sends an assert.
  always_comb
  begin
    msg_nxt = msg_r;
    msg_nxt.assertMsg = 1'b0;
    msg_nxt.deassertMsg = 1'b0;
    case (msg_r.state)
      MSG_IDLE:
      begin
        if (intxLevel)
        begin
          msg_nxt.state = MSG_ASSERTED;
          msg_nxt.assertMsg = 1'b1; // RL17
        end
      end
      MSG_ASSERTED:
      begin
        if (!intxLevel)
        begin
          msg_nxt.state = MSG_IDLE;
          msg_nxt.deassertMsg = 1'b1;
        end
      end
      default:
      begin
        msg_nxt.state = MSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      msg_r <= '{state: MSG_IDLE, assertMsg: 1'b0, deassertMsg: 1'b0};
    end
    else
    begin
      msg_r <= msg_nxt;
    end
  end

  assign assertMsg = msg_r.assertMsg;
  assign deassertMsg = msg_r.deassertMsg;

  property p_assertFollowsLevel;
    @(posedge clk) disable iff (reset)
    assertMsg |-> $past(intxLevel) && !$past(intxLevel, 2);
  endproperty
  a_assertFollowsLevel: assert property (p_assertFollowsLevel) // RL17
    else $error("Assert message without a rising gated interrupt.");

endmodule // intx_message_gen

// ===== src/gfx_function_status_class_regs.sv
`timescale 1ns/1ns
// Function
// (RL1) Status bit 15, parity error seen, always reads 0.
// (RL2) Status bit 14 reads 0; system error output never driven.
// (RL3) Status bits 13 and 12, received aborts, always read 0.
// (RL4) Status bit 11, target abort signaled, always reads 0.
// (RL5) Status select timing field, bits 10:9, fixed at 00b.
// (RL6) Status bit 8, master data parity error, always reads 0.
// (RL7) Status bit 7, back-to-back capable, always reads 1.
// (RL8) Status bits 6 and 5, user format and double speed, read 0.
// (RL9) Status bit 4 reads 1: capability pointer lives at 34h.
// (RL10) Status bit 3 reflects the live interrupt pending state.
// (RL11) Legacy interrupt asserts only when status is 1 and disable is 0.
// (RL12) Setting interrupt disable leaves the status bit unchanged.
// (RL13) One read-only 8-bit revision number, shared by functions 0 and 1.
// (RL14) Base class field reads 03h, display controller.
// (RL15) Sub-class reads 00h for VGA, 80h for non-VGA host setting.
// (RL16) Programming interface field reads 00h.
// (RL17) Command bit 10: 1 blocks interrupt and its assert messages.
// (RL18) Writes to status, revision and class code are ignored.
module gfx_function_status_class_regs
  import gfx_status_class_pkg::*;
#(
  parameter logic [7:0] REVISION = REVISION_DEFAULT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [CFG_ADDR_W-1:0] cfgAddr,
  input wire logic [CFG_BE_W-1:0] cfgByteEn,
  input wire logic [CFG_DATA_W-1:0] cfgWriteData,
  output logic [CFG_DATA_W-1:0] cfgReadData,
  output logic cfgReadDone,
  input wire logic irqPending,
  input wire logic [HOST_GFX_CTRL_W-1:0] hostGraphicsControl,
  output logic intxAssert,
  output logic intxAssertMsg,
  output logic intxDeassertMsg,
  output logic systemErrorOut
);

  typedef struct packed {
    logic intDisable;
    logic intPending;
    logic [CFG_DATA_W-1:0] readData;
    logic readDone;
  } regs_s;

  regs_s regs_r;
  regs_s regs_nxt;
  logic [DWORD_IDX_W-1:0] dwordIdx;
  logic [15:0] statusValue;
  logic [15:0] commandValue;
  logic [7:0] subClass;
  logic [23:0] classValue;
  logic intxLevel;

  assign dwordIdx = cfgAddr[CFG_ADDR_W-1:2];

  // Every status bit but the interrupt flag is a constant of the function.
  always_comb
  begin
    statusValue = 16'h0000;
    statusValue[PARITY_ERROR_SEEN_BIT] = 1'b0; // RL1
    statusValue[SYSTEM_ERROR_SIGNALED_BIT] = 1'b0; // RL2
    statusValue[MASTER_ABORT_RECEIVED_BIT] = 1'b0; // RL3
    statusValue[TARGET_ABORT_RECEIVED_BIT] = 1'b0; // RL3
    statusValue[TARGET_ABORT_SIGNALED_BIT] = 1'b0; // RL4
    statusValue[SELECT_TIMING_MSB:SELECT_TIMING_LSB] = SELECT_TIMING_VALUE; // RL5
    statusValue[MASTER_DATA_PARITY_ERROR_BIT] = 1'b0; // RL6
    statusValue[BACK_TO_BACK_CAPABLE_BIT] = 1'b1; // RL7
    statusValue[USER_FORMAT_FLAG_BIT] = 1'b0; // RL8
    statusValue[DOUBLE_SPEED_CAPABLE_BIT] = 1'b0; // RL8
    statusValue[CAPABILITY_LIST_PRESENT_BIT] = 1'b1; // RL9
    // The disable bit is deliberately not folded in here.
    statusValue[INTERRUPT_STATUS_BIT] = regs_r.intPending; // RL10 RL12
  end

  always_comb
  begin
    commandValue = 16'h0000;
    commandValue[INT_DISABLE_BIT] = regs_r.intDisable;
  end

  // The host bridge strap is read live, so a change shows on the next read.
  assign subClass = hostGraphicsControl[HOST_GFX_NON_VGA_BIT] ?
    SUB_CLASS_NON_VGA : SUB_CLASS_VGA; // RL15
  assign classValue = {BASE_CLASS_DISPLAY, subClass, PROGRAMMING_INTERFACE_DISPLAY}; // RL14 RL16

  always_comb
  begin
    regs_nxt = regs_r;
    regs_nxt.readDone = 1'b0;
    regs_nxt.intPending = irqPending; // RL10
    if (cfgWrite && (dwordIdx == CMD_STATUS_DWORD) && cfgByteEn[INT_DISABLE_LANE])
    begin
      // Only the disable bit is writable; the status half of the dword is dropped.
      regs_nxt.intDisable = cfgWriteData[INT_DISABLE_BIT]; // RL17 RL18
    end
    if (cfgRead)
    begin
      regs_nxt.readDone = 1'b1;
      if (dwordIdx == CMD_STATUS_DWORD)
      begin
        regs_nxt.readData = {statusValue, commandValue};
      end
      else if (dwordIdx == REV_CLASS_DWORD)
      begin
        regs_nxt.readData = {classValue, REVISION}; // RL13
      end
      else
      begin
        // Other header registers live elsewhere and read as zero here.
        regs_nxt.readData = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      regs_r <= '{intDisable: INT_DISABLE_RESET, intPending: 1'b0,
        readData: '0, readDone: 1'b0};
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  assign intxLevel = regs_r.intPending && !regs_r.intDisable; // RL11 RL17
  assign intxAssert = intxLevel;
  assign cfgReadData = regs_r.readData;
  assign cfgReadDone = regs_r.readDone;
  assign systemErrorOut = 1'b0; // RL2

  intx_message_gen u_intx_message_gen (
    .clk(clk),
    .reset(reset),
    .intxLevel(intxLevel),
    .assertMsg(intxAssertMsg),
    .deassertMsg(intxDeassertMsg)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_errorBitsZero;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadDone && (cfgReadData[31:27] == 5'h00);
  endproperty
  a_errorBitsZero: assert property (p_errorBitsZero) // RL1 RL2 RL3 RL4
    else $error("Status error bits not zero.");

  property p_selectTiming;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadData[26:25] == 2'h0;
  endproperty
  a_selectTiming: assert property (p_selectTiming) // RL5
    else $error("Select timing field not 00b.");

  property p_masterParity;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> !cfgReadData[24];
  endproperty
  a_masterParity: assert property (p_masterParity) // RL6
    else $error("Master data parity error bit set.");

  property p_backToBack;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadData[23];
  endproperty
  a_backToBack: assert property (p_backToBack) // RL7
    else $error("Back-to-back capable bit not set.");

  property p_formatSpeed;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadData[22:21] == 2'h0;
  endproperty
  a_formatSpeed: assert property (p_formatSpeed) // RL8
    else $error("User format or double speed bit set.");

  property p_capList;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadData[20];
  endproperty
  a_capList: assert property (p_capList) // RL9
    else $error("Capability list bit not set.");

  property p_intStatus;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> cfgReadData[19] == $past(irqPending, 2);
  endproperty
  a_intStatus: assert property (p_intStatus) // RL10
    else $error("Interrupt status does not track the pending interrupt.");

  property p_intxGate;
    intxAssert |-> $past(irqPending) && !regs_r.intDisable;
  endproperty
  a_intxGate: assert property (p_intxGate) // RL11
    else $error("Interrupt asserted without pending status or while disabled.");

  property p_disableKeepsStatus;
    regs_r.intDisable && cfgRead && (dwordIdx == CMD_STATUS_DWORD)
      |=> cfgReadData[19] == $past(irqPending, 2);
  endproperty
  a_disableKeepsStatus: assert property (p_disableKeepsStatus) // RL12
    else $error("Interrupt disable altered the status bit.");

  property p_revision;
    cfgRead && (dwordIdx == REV_CLASS_DWORD) |=> cfgReadData[7:0] == REVISION;
  endproperty
  a_revision: assert property (p_revision) // RL13
    else $error("Revision number mismatch.");

  property p_classFixed;
    cfgRead && (dwordIdx == REV_CLASS_DWORD)
      |=> (cfgReadData[31:24] == 8'h03) && (cfgReadData[15:8] == 8'h00);
  endproperty
  a_classFixed: assert property (p_classFixed) // RL14 RL16
    else $error("Base class or programming interface wrong.");

  property p_subClass;
    cfgRead && (dwordIdx == REV_CLASS_DWORD) |=> cfgReadData[23:16] ==
      ($past(hostGraphicsControl[HOST_GFX_NON_VGA_BIT]) ? 8'h80 : 8'h00);
  endproperty
  a_subClass: assert property (p_subClass) // RL15
    else $error("Sub-class does not follow the host graphics setting.");

  property p_disableBlocks;
    regs_r.intDisable |-> !intxAssert ##1 !intxAssertMsg;
  endproperty
  a_disableBlocks: assert property (p_disableBlocks) // RL17
    else $error("Interrupt or assert message while disabled.");

  property p_writeIgnored;
    cfgWrite && !cfgByteEn[INT_DISABLE_LANE] |=> $stable(regs_r.intDisable);
  endproperty
  a_writeIgnored: assert property (p_writeIgnored) // RL18
    else $error("Write outside the command lane changed state.");

  property p_statusIdle;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) && !regs_r.intPending
      |=> cfgReadData[31:16] == FUNCTION_STATUS_RESET;
  endproperty
  a_statusIdle: assert property (p_statusIdle) // RL1 RL9
    else $error("Status does not read its reset value while idle.");

  property p_statusPending;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) && regs_r.intPending
      |=> cfgReadData[31:16] == (FUNCTION_STATUS_RESET | 16'h0008);
  endproperty
  a_statusPending: assert property (p_statusPending) // RL10
    else $error("Status does not show the pending interrupt.");

  property p_disableReadback;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD)
      |=> cfgReadData[INT_DISABLE_BIT] == $past(regs_r.intDisable);
  endproperty
  a_disableReadback: assert property (p_disableReadback) // RL17
    else $error("Interrupt disable does not read back.");

  property p_commandOthersZero;
    cfgRead && (dwordIdx == CMD_STATUS_DWORD) |=> (cfgReadData[15:0] & 16'hFBFF) == 16'h0000;
  endproperty
  a_commandOthersZero: assert property (p_commandOthersZero) // RL17
    else $error("Command bits other than the disable bit are not zero.");

  property p_disableWrite;
    cfgWrite && (dwordIdx == CMD_STATUS_DWORD) && cfgByteEn[INT_DISABLE_LANE]
      |=> regs_r.intDisable == $past(cfgWriteData[INT_DISABLE_BIT]);
  endproperty
  a_disableWrite: assert property (p_disableWrite) // RL17
    else $error("Interrupt disable write did not land.");

  property p_otherDwordWrite;
    cfgWrite && (dwordIdx != CMD_STATUS_DWORD) |=> $stable(regs_r.intDisable);
  endproperty
  a_otherDwordWrite: assert property (p_otherDwordWrite) // RL18
    else $error("Write to a read-only dword changed state.");

  property p_classVga;
    cfgRead && (dwordIdx == REV_CLASS_DWORD) && !hostGraphicsControl[HOST_GFX_NON_VGA_BIT]
      |=> cfgReadData[31:8] == FUNCTION_CLASS_RESET;
  endproperty
  a_classVga: assert property (p_classVga) // RL14 RL15 RL16
    else $error("Class code differs from its default in VGA mode.");

  property p_intxIdle;
    !regs_r.intPending |-> !intxAssert;
  endproperty
  a_intxIdle: assert property (p_intxIdle) // RL11
    else $error("Interrupt asserted with nothing pending.");

  // The reset guard matters because the first edge still sees cleared state.
  property p_intxFollows;
    !$past(reset) && $past(irqPending) && !regs_r.intDisable |-> intxAssert;
  endproperty
  a_intxFollows: assert property (p_intxFollows) // RL10 RL11
    else $error("Pending enabled interrupt not asserted.");

  property p_assertMsgOnRise;
    !intxAssert ##1 intxAssert |=> intxAssertMsg;
  endproperty
  a_assertMsgOnRise: assert property (p_assertMsgOnRise) // RL17
    else $error("No assert message after the interrupt rose.");

  property p_deassertMsgOnFall;
    intxAssert ##1 !intxAssert |=> intxDeassertMsg;
  endproperty
  a_deassertMsgOnFall: assert property (p_deassertMsgOnFall) // RL17
    else $error("No deassert message after the interrupt fell.");

  property p_sysErrLow;
    !systemErrorOut;
  endproperty
  a_sysErrLow: assert property (p_sysErrLow) // RL2
    else $error("System error output driven active.");

endmodule // gfx_function_status_class_regs

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import gfx_status_class_pkg::*;
  // Revision value is arbitrary; it only has to differ from the default.
  localparam logic [7:0] REV = 8'h5A;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfgRead = 1'b0;
  logic cfgWrite = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWriteData = 32'h0;
  logic irqPending = 1'b0;
  logic [15:0] hostGraphicsControl = 16'h0;
  logic [31:0] cfgReadData;
  logic cfgReadDone, intxAssert, intxAssertMsg, intxDeassertMsg, systemErrorOut;
  int errors = 0;
  int samples_checked = 0;
  bit sawUp, sawDown;

  gfx_function_status_class_regs #(.REVISION(REV)) uut (
    .clk(clk), .reset(reset), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .cfgReadDone(cfgReadDone), .irqPending(irqPending),
    .hostGraphicsControl(hostGraphicsControl), .intxAssert(intxAssert),
    .intxAssertMsg(intxAssertMsg), .intxDeassertMsg(intxDeassertMsg),
    .systemErrorOut(systemErrorOut)
  );

  initial
  begin
    forever #50 clk = ~clk;
  end

  // Messages are one-cycle pulses, so they are latched on the quiet edge.
  always @(negedge clk)
  begin
    if (intxAssertMsg === 1'b1) sawUp = 1'b1;
    if (intxDeassertMsg === 1'b1) sawDown = 1'b1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    @(negedge clk);
    chk("readDone", 32'h1, {31'h0, cfgReadDone});
    chk("readData", exp, cfgReadData);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWriteData <= d;
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask

  task automatic irqLevel(input logic lvl, input logic [31:0] expInt);
    @(posedge clk);
    irqPending <= lvl;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("intxAssert", expInt, {31'h0, intxAssert});
  endtask

  task automatic close_out;
    $display("Counts: %0d checked, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(8'h04, 32'h00900000);
    rd(8'h08, {24'h030000, REV});
    chk("sysErr", 32'h0, {31'h0, systemErrorOut});
    $display("Test reset values done");

    @(posedge clk);
    hostGraphicsControl <= 16'h0002;
    rd(8'h0B, {24'h038000, REV});
    @(posedge clk);
    hostGraphicsControl <= 16'hFFFD;
    rd(8'h08, {24'h030000, REV});
    $display("Test sub-class done");

    wr(8'h08, 4'hF, 32'hFFFFFFFF);
    wr(8'h04, 4'hF, 32'hFFFFFBFF);
    rd(8'h04, 32'h00900000);
    wr(8'h04, 4'hD, 32'hFFFFFFFF);
    rd(8'h04, 32'h00900000);
    rd(8'h08, {24'h030000, REV});
    rd(8'h0C, 32'h0);
    $display("Test write protection done");

    sawUp = 1'b0;
    irqLevel(1'b1, 32'h1);
    chk("assertMsg", 32'h1, {31'h0, sawUp});
    rd(8'h06, 32'h00980000);
    sawDown = 1'b0;
    wr(8'h04, 4'h2, 32'h00000400);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("intxAssert", 32'h0, {31'h0, intxAssert});
    chk("deassertMsg", 32'h1, {31'h0, sawDown});
    rd(8'h04, 32'h00980400);
    $display("Test disable while pending done");

    irqLevel(1'b0, 32'h0);
    sawUp = 1'b0;
    irqLevel(1'b1, 32'h0);
    chk("assertMsg", 32'h0, {31'h0, sawUp});
    rd(8'h04, 32'h00980400);
    wr(8'h04, 4'h2, 32'h00000000);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("intxAssert", 32'h1, {31'h0, intxAssert});
    chk("assertMsg", 32'h1, {31'h0, sawUp});
    sawDown = 1'b0;
    irqLevel(1'b0, 32'h0);
    chk("deassertMsg", 32'h1, {31'h0, sawDown});
    rd(8'h04, 32'h00900000);
    chk("sysErr", 32'h0, {31'h0, systemErrorOut});
    $display("Test interrupt gating done");
    close_out();
  end
endmodule // tb_top
